// File: verilog/adcseq_pkg.sv
// Constants and types for the converter sequencer and trigger control.
// Assumes an APB master on pclk and a converter core returning two 12-bit words.
package adcseq_pkg;

    // ************************************
    // Sizes and timing
    // ************************************
    localparam int         NSMP     = 20;
    localparam logic [4:0] NIN      = 5'hA;
    localparam logic [3:0] SAMP_CYC = 4'h3;
    localparam logic [3:0] CONV_CYC = 4'hD;

    // ************************************
    // Register offsets
    // ************************************
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TRIG      = 8'h04;
    localparam logic [7:0] OFS_CNT       = 8'h08;
    localparam logic [7:0] OFS_STAT      = 8'h0C;
    localparam logic [7:0] OFS_THR       = 8'h10;
    localparam logic [7:0] OFS_CHSEL     = 8'h20;
    localparam logic [7:0] OFS_CHSEL_END = 8'h48;
    localparam logic [7:0] OFS_RES       = 8'h80;
    localparam logic [7:0] OFS_RES_END   = 8'hD0;

    // ************************************
    // Field positions
    // ************************************
    localparam int CTRL_MODE   = 0;
    localparam int CTRL_ALIGN  = 2;
    localparam int CTRL_THUP   = 3;
    localparam int CTRL_SWTRIG = 4;
    localparam int TRIG_PWM    = 0;
    localparam int TRIG_TMR    = 4;
    localparam int TRIG_CNT    = 8;
    localparam int CHS_EVEN    = 0;
    localparam int CHS_ODD     = 8;
    localparam int STAT_DONE   = 0;
    localparam int STAT_ROUND  = 4;
    localparam int STAT_ABN    = 5;
    localparam int STAT_THR    = 6;

    // ************************************
    // Reset values
    // ************************************
    localparam logic [15:0] RST_CNT = 16'h1111;
    localparam logic [15:0] RST_THR = 16'h0000;

    // ************************************
    // Types
    // ************************************
    typedef enum logic [1:0] {
        MODE_ONE  = 2'b00,
        MODE_TWO  = 2'b01,
        MODE_FOUR = 2'b10
    } adcseq_mode_t;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b00,
        FSM_SAMP = 2'b01,
        FSM_CONV = 2'b10
    } adcseq_fsm_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } adcseq_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } adcseq_apb_rsp_t;

    typedef struct packed {
        logic [11:0] data_a;
        logic [11:0] data_b;
    } adcseq_conv_t;

    typedef struct packed {
        logic [3:0] sel_a;
        logic [3:0] sel_b;
        logic       hold;
        logic       trig_ind;
    } adcseq_pins_t;

    typedef struct packed {
        logic [3:0] stage_done;
        logic       round_done;
        logic       abnormal;
        logic       thr_hit;
        logic       busy;
    } adcseq_flags_t;

    typedef struct packed {
        adcseq_mode_t           mode;
        logic                   align_left;
        logic                   th_upper;
        logic [3:0]             pwm_en;
        logic [3:0]             tmr_en;
        logic [3:0]             trig_n;
        logic [15:0]            cnt_cfg;
        logic [15:0]            thresh;
        logic [NSMP-1:0][4:0]   chsel;
        logic [NSMP-1:0][15:0]  res;
        adcseq_fsm_t            st;
        logic [3:0]             cyc;
        logic                   second;
        logic [1:0]             stage;
        logic [3:0]             taken;
        logic [4:0]             idx;
        logic [3:0]             trig_cnt;
        adcseq_pins_t           pins;
        adcseq_flags_t          flags;
        adcseq_apb_rsp_t        rsp;
    } adcseq_state_t;

endpackage : adcseq_pkg

// File: verilog/adcseq_ctrl.sv
// Sequencer and trigger control for a dual sample-and-hold converter.
// Assumes APB master, trigger pulses and converter data on pclk.
//
// Contract
// R1: sample two circuits together, convert in turn
// R2: each circuit picks among ten inputs
// R3: conversion is 3 sample plus 13 cycles
// R4: select fields at [4:0] and [12:8]
// R5: even and odd sample taken together
// R6: stage sample count equals its field; a zero field takes one sample
// R7: odd count converts one value last
// R8: trigger source chosen by trigger config
// R9: round done flag after whole round
// R10: each stage raises its own done flag
// R11: wait idle for next stage trigger
// R12: rounds of one, two or four stages
// R13: single stage counts N triggers first
// R14: two stages start on T0, T1
// R15: four stages start on T0 to T3
// R16: single stage any trigger, software once
// R17: both hardware sources may be enabled
// R18: trigger indication output for debugging
// R19: stage counts in four-bit fields
// R20: software powers converter up in order
// R21: trigger while busy flags abnormal event
// R22: first result compared against threshold
// R23: results left padded or sign extended
// R24: results fill in order, pointer wraps
// R25: status flags cleared by writing one
`timescale 1ns/1ns
module adcseq_ctrl (
    // Clock, reset, enable
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    // APB slave
    input  wire adcseq_pkg::adcseq_apb_req_t apb_req,
    output      adcseq_pkg::adcseq_apb_rsp_t apb_rsp,
    // Timed triggers
    input  wire logic [3:0]               pwm_timed_conversion_trigger,
    input  wire logic [3:0]               tmr_timed_conversion_trigger,
    // Converter core
    input  wire adcseq_pkg::adcseq_conv_t conv,
    output      adcseq_pkg::adcseq_pins_t pins,
    // Event flags
    output      adcseq_pkg::adcseq_flags_t flags
);
    import adcseq_pkg::*;

    // ************************************
    // Helpers
    // ************************************
    function automatic logic [3:0] route(input logic [4:0] ch);
        logic [4:0] k;
        k = (ch >= NIN) ? ch - NIN : ch;
        return k[3:0];
    endfunction : route

    function automatic logic [15:0] fmt(input logic [11:0] d, input logic left);
        return left ? {d, 4'h0} : {{4{d[11]}}, d};
    endfunction : fmt

    function automatic logic [32:0] rd_reg(input adcseq_state_t s, input logic [7:0] a);
        logic [7:0]  d;
        logic [32:0] q;
        d = 8'h00;
        q = {1'b1, 32'h0};
        case (a)
            OFS_CTRL: q[31:0] = {28'h0, s.th_upper, s.align_left, s.mode};
            OFS_TRIG: q[31:0] = {20'h0, s.trig_n, s.tmr_en, s.pwm_en};
            OFS_CNT:  q[31:0] = {16'h0, s.cnt_cfg};
            OFS_STAT: q[31:0] = {21'h0, s.stage, s.flags.busy, 1'b0, s.flags.thr_hit,
                                 s.flags.abnormal, s.flags.round_done, s.flags.stage_done};
            OFS_THR:  q[31:0] = {16'h0, s.thresh};
            default: begin
                if (a >= OFS_CHSEL && a < OFS_CHSEL_END) begin
                    d = a - OFS_CHSEL;
                    q[31:0] = {19'h0, s.chsel[{d[5:2], 1'b1}], 3'h0, s.chsel[{d[5:2], 1'b0}]};
                end else if (a >= OFS_RES && a < OFS_RES_END) begin
                    d = a - OFS_RES;
                    q[31:0] = {16'h0, s.res[d[6:2]]};
                end else begin
                    q[32] = 1'b0;
                end
            end
        endcase
        return q;
    endfunction : rd_reg

    // ************************************
    // State and decode
    // ************************************
    localparam adcseq_state_t S_RST = '{cnt_cfg: RST_CNT, thresh: RST_THR,
                                        mode: MODE_ONE, st: FSM_IDLE, default: '0};

    adcseq_state_t r;
    adcseq_state_t n;
    logic [3:0]    ev;
    logic          hw_hit;
    logic          setup;
    logic          wr;
    logic          sw_fire;
    logic [3:0]    cnt;
    logic [3:0]    goal;
    logic [1:0]    last_stage;
    logic          store;
    logic [32:0]   rd;
    logic [7:0]    wa;
    logic [31:0]   wd;

    assign wa = apb_req.paddr;
    assign wd = apb_req.pwdata;
    assign ev = (pwm_timed_conversion_trigger & r.pwm_en) | (tmr_timed_conversion_trigger & r.tmr_en); // [R8] [R17]
    // Single stage takes any enabled line; multi-stage only the current one
    assign hw_hit = (r.mode == MODE_ONE) ? |ev : ev[r.stage]; // [R14] [R15] [R16]
    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr = apb_req.psel & apb_req.penable & r.rsp.pready & apb_req.pwrite;
    assign sw_fire = wr && wa == OFS_CTRL && wd[CTRL_SWTRIG];
    // Zero count is taken as one sample so a stage always ends
    assign cnt = (r.cnt_cfg[{r.stage, 2'b00} +: 4] == 4'h0) ? 4'h1
               : r.cnt_cfg[{r.stage, 2'b00} +: 4]; // [R6] [R19]
    assign goal = (r.trig_n == 4'h0) ? 4'h1 : r.trig_n;
    assign last_stage = (r.mode == MODE_ONE) ? 2'b00
                      : (r.mode == MODE_TWO) ? 2'b01 : 2'b11; // [R12]
    assign store = (r.st == FSM_CONV) && (r.cyc == CONV_CYC - 4'h1);
    assign rd = rd_reg(r, wa);

    // ************************************
    // Next state
    // ************************************
    always_comb begin
        logic        go;
        logic [15:0] v;
        logic [4:0]  nb;
        logic [7:0]  d;
        go = 1'b0;
        v = 16'h0;
        nb = 5'h0;
        d = wa - OFS_CHSEL;
        n = r;
        n.pins.trig_ind = 1'b0;

        // APB: answer one cycle after setup, zero wait states
        n.rsp.pready = setup;
        if (setup) begin
            n.rsp.prdata = apb_req.pwrite ? 32'h0 : rd[31:0];
            n.rsp.pslverr = ~rd[32];
        end
        if (wr) begin
            case (wa)
                OFS_CTRL: begin
                    n.mode = adcseq_mode_t'(wd[CTRL_MODE +: 2]);
                    n.align_left = wd[CTRL_ALIGN];
                    n.th_upper = wd[CTRL_THUP];
                end
                OFS_TRIG: begin
                    n.pwm_en = wd[TRIG_PWM +: 4];
                    n.tmr_en = wd[TRIG_TMR +: 4];
                    n.trig_n = wd[TRIG_CNT +: 4];
                    n.trig_cnt = 4'h0;
                end
                OFS_CNT: n.cnt_cfg = wd[15:0]; // [R19]
                OFS_STAT: begin
                    // Sets below come later, so an event beats its clear
                    n.flags.stage_done = r.flags.stage_done & ~wd[STAT_DONE +: 4]; // [R25]
                    n.flags.round_done = r.flags.round_done & ~wd[STAT_ROUND]; // [R25]
                    n.flags.abnormal = r.flags.abnormal & ~wd[STAT_ABN]; // [R25]
                    n.flags.thr_hit = r.flags.thr_hit & ~wd[STAT_THR]; // [R25]
                end
                OFS_THR: n.thresh = wd[15:0];
                default: begin
                    if (wa >= OFS_CHSEL && wa < OFS_CHSEL_END) begin
                        n.chsel[{d[5:2], 1'b0}] = wd[CHS_EVEN +: 5]; // [R4]
                        n.chsel[{d[5:2], 1'b1}] = wd[CHS_ODD +: 5]; // [R4]
                    end
                end
            endcase
        end

        // A trigger during a stage is not queued, only reported
        if (r.st != FSM_IDLE && (|ev || sw_fire)) begin
            n.flags.abnormal = 1'b1; // [R21]
        end

        case (r.st)
            FSM_IDLE: begin
                if (r.mode == MODE_ONE) begin
                    if (sw_fire) begin
                        go = 1'b1; // [R16]
                    end else if (hw_hit) begin
                        if (r.trig_cnt + 4'h1 >= goal) begin
                            go = 1'b1; // [R13]
                            n.trig_cnt = 4'h0;
                        end else begin
                            n.trig_cnt = r.trig_cnt + 4'h1; // [R13]
                        end
                    end
                end else if (hw_hit || sw_fire) begin
                    go = 1'b1; // [R11] [R14] [R15]
                end
            end
            FSM_SAMP: begin
                if (r.cyc == SAMP_CYC - 4'h1) begin
                    n.st = FSM_CONV; // [R3]
                    n.cyc = 4'h0;
                    n.pins.hold = 1'b0;
                end else begin
                    n.cyc = r.cyc + 4'h1;
                end
            end
            FSM_CONV: begin
                if (store) begin
                    v = fmt(r.second ? conv.data_b : conv.data_a, r.align_left); // [R1] [R23]
                    if (r.idx < 5'(NSMP)) begin
                        n.res[r.idx] = v; // [R24]
                    end
                    if (r.idx == 5'h0 && (r.th_upper ? $signed(v) > $signed(r.thresh)
                                                     : $signed(v) < $signed(r.thresh))) begin
                        n.flags.thr_hit = 1'b1; // [R22]
                    end
                    n.idx = r.idx + 5'h1; // [R24]
                    n.taken = r.taken + 4'h1;
                    n.cyc = 4'h0;
                    if (r.taken + 4'h1 == cnt) begin
                        // Odd count ends here with the second value unused
                        n.st = FSM_IDLE; // [R7] [R11]
                        n.second = 1'b0;
                        n.flags.stage_done[r.stage] = 1'b1; // [R10]
                        if (r.stage == last_stage) begin
                            n.flags.round_done = 1'b1; // [R9]
                            n.stage = 2'b00; // [R24]
                            n.idx = 5'h0;
                        end else begin
                            n.stage = r.stage + 2'b01;
                        end
                    end else if (!r.second) begin
                        // Second held value: its own 16-cycle slot, no new sample
                        n.second = 1'b1; // [R1] [R3]
                        n.st = FSM_SAMP;
                    end else begin
                        nb = (r.idx + 5'h2 >= 5'(NSMP)) ? r.idx + 5'h1 : r.idx + 5'h2;
                        n.second = 1'b0;
                        n.st = FSM_SAMP;
                        n.pins.hold = 1'b1; // [R5]
                        n.pins.sel_a = route(r.chsel[r.idx + 5'h1]); // [R2] [R5]
                        n.pins.sel_b = route(r.chsel[nb]); // [R2] [R5]
                    end
                end else begin
                    n.cyc = r.cyc + 4'h1;
                end
            end
            default: n.st = FSM_IDLE;
        endcase

        if (go) begin
            nb = (r.idx + 5'h1 >= 5'(NSMP)) ? r.idx : r.idx + 5'h1;
            n.st = FSM_SAMP;
            n.cyc = 4'h0;
            n.taken = 4'h0;
            n.second = 1'b0;
            n.pins.trig_ind = 1'b1; // [R18]
            n.pins.hold = 1'b1; // [R1] [R5]
            n.pins.sel_a = route(r.chsel[r.idx]); // [R2]
            n.pins.sel_b = route(r.chsel[nb]); // [R2]
        end
        n.flags.busy = (n.st != FSM_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= S_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    assign apb_rsp = r.rsp;
    assign pins = r.pins;
    assign flags = r.flags;

    // ************************************
    // Check helpers
    // ************************************
    // Run of conversion cycles; counted, not repeated in a sequence
    logic [4:0] conv_run_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_run_reg <= 5'h00;
        end else if (ce) begin
            conv_run_reg <= (r.st == FSM_CONV) ? conv_run_reg + 5'h01 : 5'h00;
        end
    end

    // ************************************
    // Checks
    // ************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    property p_hold_len;
        $rose(r.pins.hold) |-> r.pins.hold [*3] ##1 !r.pins.hold;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold not 3 cycles"); // [R3]

    property p_conv_len;
        (r.st == FSM_CONV && n.st != FSM_CONV) |-> conv_run_reg == {1'b0, CONV_CYC - 4'h1};
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conv not 13 cycles"); // [R3]

    property p_conv_start;
        $fell(r.pins.hold) |-> r.st == FSM_CONV && conv_run_reg == 5'h00;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("conv start wrong"); // [R3]

    property p_trig_ind;
        r.pins.trig_ind |-> r.pins.hold && r.st == FSM_SAMP && r.cyc == 4'h0;
    endproperty
    a_trig_ind: assert property (p_trig_ind) else $error("trig ind w/o start"); // [R18]

    property p_abn;
        (r.st != FSM_IDLE && |ev) |=> r.flags.abnormal;
    endproperty
    a_abn: assert property (p_abn) else $error("busy trigger not flagged"); // [R21]

    property p_count;
        (r.st == FSM_IDLE && r.mode == MODE_ONE && hw_hit && !sw_fire
         && r.trig_cnt + 4'h1 < goal) |=> r.st == FSM_IDLE;
    endproperty
    a_count: assert property (p_count) else $error("started before N"); // [R13]

    property p_multi;
        (r.st == FSM_IDLE && r.mode != MODE_ONE && hw_hit) |=> r.st == FSM_SAMP && r.pins.hold;
    endproperty
    a_multi: assert property (p_multi) else $error("stage trigger missed"); // [R11]

    property p_odd;
        (store && !r.second && r.taken + 4'h1 == cnt) |=> r.st == FSM_IDLE && !r.pins.hold;
    endproperty
    a_odd: assert property (p_odd) else $error("odd end converted twice"); // [R7]

    property p_left;
        (store && r.align_left && r.idx < 5'(NSMP)) |=> r.res[$past(r.idx)][3:0] == 4'h0;
    endproperty
    a_left: assert property (p_left) else $error("left align not padded"); // [R23]

    property p_round;
        $rose(r.flags.round_done) |-> r.stage == 2'b00 && r.idx == 5'h0 && !r.flags.busy;
    endproperty
    a_round: assert property (p_round) else $error("round end bad pointer"); // [R9]

    property p_stage;
        (store && r.taken + 4'h1 == cnt) |=> r.flags.stage_done[$past(r.stage)];
    endproperty
    a_stage: assert property (p_stage) else $error("stage done not set"); // [R10]

    property p_skip;
        (r.st == FSM_IDLE && r.mode != MODE_ONE && !hw_hit && !sw_fire) |=> r.st == FSM_IDLE;
    endproperty
    a_skip: assert property (p_skip) else $error("wrong stage trigger"); // [R14] [R15]

    property p_sw;
        (r.st == FSM_IDLE && sw_fire) |=> r.st == FSM_SAMP && r.pins.trig_ind;
    endproperty
    a_sw: assert property (p_sw) else $error("software trigger missed"); // [R16]

    property p_ind_pulse;
        r.pins.trig_ind |=> !r.pins.trig_ind;
    endproperty
    a_ind_pulse: assert property (p_ind_pulse) else $error("trig ind too long"); // [R18]

endmodule : adcseq_ctrl

// File: sim/adcseq_trig_model.sv
// Behavioural model of the PWM unit and general timer trigger outputs.
// Assumes the bench asks for pulses through go with one mask per source.
`timescale 1ns/1ns
module adcseq_trig_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench request
    input  wire logic       go,
    input  wire logic [3:0] pwm_sel,
    input  wire logic [3:0] tmr_sel,
    // Timed trigger pulses
    output      logic [3:0] pwm_timed_conversion_trigger,
    output      logic [3:0] tmr_timed_conversion_trigger
);
    // ************************************
    // Pulse generation
    // ************************************
    // One-cycle pulses; several lines and both units may fire at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_timed_conversion_trigger <= 4'h0;
            tmr_timed_conversion_trigger <= 4'h0;
        end else begin
            pwm_timed_conversion_trigger <= go ? pwm_sel : 4'h0;
            tmr_timed_conversion_trigger <= go ? tmr_sel : 4'h0;
        end
    end
endmodule : adcseq_trig_model

// File: sim/testbench.sv
// Self-checking bench for the converter sequencer and trigger control.
// Assumes the trigger model on the far side and a constant converter result.
`timescale 1ns/1ns
module testbench;
    import adcseq_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

    logic            pclk;
    logic            presetn;
    logic            ce;
    adcseq_apb_req_t apb_req;
    adcseq_apb_rsp_t apb_rsp;
    logic [3:0]      pwm_timed_conversion_trigger;
    logic [3:0]      tmr_timed_conversion_trigger;
    adcseq_conv_t    conv;
    adcseq_pins_t    pins;
    adcseq_flags_t   flags;
    logic            go;
    logic [3:0]      pwm_sel;
    logic [3:0]      tmr_sel;
    logic [31:0]     rd;
    logic            err;
    logic [3:0]      sel_a0;
    logic [3:0]      sel_b0;
    int              miscompares;
    int              comparisons;
    int              busy_cnt;
    int              hold_cnt;
    int              ind_cnt;

    adcseq_ctrl i_adcseq_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pwm_timed_conversion_trigger(pwm_timed_conversion_trigger), .tmr_timed_conversion_trigger(tmr_timed_conversion_trigger), .conv(conv),
        .pins(pins), .flags(flags));
    adcseq_trig_model i_adcseq_trig_model (.pclk(pclk), .presetn(presetn), .go(go),
        .pwm_sel(pwm_sel), .tmr_sel(tmr_sel), .pwm_timed_conversion_trigger(pwm_timed_conversion_trigger), .tmr_timed_conversion_trigger(tmr_timed_conversion_trigger));

    always #50 pclk = ~pclk;

    // ************************************
    // Activity counters
    // ************************************
    always @(posedge pclk) begin
        if (pins.hold === 1'b1 && hold_cnt == 0) begin
            sel_a0 = pins.sel_a;
            sel_b0 = pins.sel_b;
        end
        if (pins.hold === 1'b1) hold_cnt++;
        if (flags.busy === 1'b1) busy_cnt++;
        if (pins.trig_ind === 1'b1) ind_cnt++;
    end

    // ************************************
    // Bus and trigger tasks
    // ************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask : rdchk

    task automatic fire(input logic [3:0] p, input logic [3:0] t);
        @(posedge pclk);
        go      <= 1'b1;
        pwm_sel <= p;
        tmr_sel <= t;
        @(posedge pclk);
        go      <= 1'b0;
    endtask : fire

    // Busy only shows a few edges after the start request
    task automatic wait_idle;
        repeat (3) @(posedge pclk);
        do begin
            @(posedge pclk);
        end while (flags.busy !== 1'b0);
    endtask : wait_idle

    task automatic clr;
        @(negedge pclk);
        busy_cnt = 0;
        hold_cnt = 0;
        ind_cnt  = 0;
    endtask : clr

    // ************************************
    // Scenarios
    // ************************************
    task automatic t_reset;
        rdchk(OFS_CNT, {16'h0000, RST_CNT});
        rdchk(OFS_STAT, 32'h0000_0000);
        apb(1'b0, 8'h60, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, OFS_RES, 32'h0000_FFFF);
        rdchk(OFS_RES, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_single_sw;
        conv.data_a <= 12'h80D;
        conv.data_b <= 12'h123;
        apb(1'b1, OFS_CHSEL, 32'h0000_0F03);
        apb(1'b1, OFS_CNT, 32'h0000_0003);
        clr();
        apb(1'b1, OFS_CTRL, 32'h0000_0010);
        wait_idle();
        `CHK(sel_a0, 4'h3)
        `CHK(sel_b0, 4'h5)
        `CHK(busy_cnt, 48)
        `CHK(hold_cnt, 6)
        `CHK(ind_cnt, 1)
        rdchk(OFS_RES, 32'h0000_F80D);
        rdchk(OFS_RES + 8'h04, 32'h0000_0123);
        rdchk(OFS_RES + 8'h08, 32'h0000_F80D);
        rdchk(OFS_RES + 8'h0C, 32'h0000_0000);
        rdchk(OFS_STAT, 32'h0000_0051);
        rdchk(OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_STAT, 32'h0000_007F);
        rdchk(OFS_STAT, 32'h0000_0000);
        $display("test single software done");
    endtask : t_single_sw

    task automatic t_hw_count;
        // One source family enabled at a time
        apb(1'b1, OFS_TRIG, 32'h0000_0204);
        apb(1'b1, OFS_CNT, 32'h0000_0001);
        clr();
        fire(4'h4, 4'h0);
        repeat (4) @(posedge pclk);
        `CHK(flags.busy, 1'b0)
        fire(4'h0, 4'h4);
        repeat (4) @(posedge pclk);
        `CHK(flags.busy, 1'b0)
        fire(4'h4, 4'h0);
        wait_idle();
        `CHK(ind_cnt, 1)
        apb(1'b1, OFS_TRIG, 32'h0000_01F0);
        fire(4'h0, 4'h8);
        repeat (5) @(posedge pclk);
        fire(4'h0, 4'h1);
        wait_idle();
        `CHK(flags.abnormal, 1'b1)
        `CHK(ind_cnt, 2)
        apb(1'b1, OFS_STAT, 32'h0000_007F);
        $display("test hardware count done");
    endtask : t_hw_count

    task automatic t_two_stage;
        conv.data_a <= 12'h456;
        conv.data_b <= 12'h456;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_TRIG, 32'h0000_0003);
        apb(1'b1, OFS_CNT, 32'h0000_0011);
        fire(4'h2, 4'h0);
        repeat (4) @(posedge pclk);
        `CHK(flags.busy, 1'b0)
        fire(4'h1, 4'h0);
        wait_idle();
        `CHK(flags.stage_done, 4'h1)
        `CHK(flags.round_done, 1'b0)
        fire(4'h2, 4'h0);
        wait_idle();
        `CHK(flags.stage_done, 4'h3)
        `CHK(flags.round_done, 1'b1)
        rdchk(OFS_RES + 8'h04, 32'h0000_0456);
        apb(1'b1, OFS_STAT, 32'h0000_007F);
        $display("test two stage done");
    endtask : t_two_stage

    task automatic t_four_stage;
        conv.data_a <= 12'h80D;
        conv.data_b <= 12'h123;
        apb(1'b1, OFS_THR, 32'h0000_8000);
        apb(1'b1, OFS_CTRL, 32'h0000_000E);
        apb(1'b1, OFS_CNT, 32'h0000_1111);
        clr();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFS_CTRL, 32'h0000_001E);
            wait_idle();
            `CHK(flags.stage_done[k], 1'b1)
            `CHK(flags.round_done, (k == 3))
        end
        `CHK(ind_cnt, 4)
        `CHK(flags.thr_hit, 1'b1)
        rdchk(OFS_RES, 32'h0000_80D0);
        rdchk(OFS_STAT, 32'h0000_005F);
        $display("test four stage done");
    endtask : t_four_stage

    task automatic end_sim;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // ************************************
    // Main sequence and watchdog
    // ************************************
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        ce          = 1'b1;
        apb_req     = '0;
        conv        = '0;
        go          = 1'b0;
        pwm_sel     = 4'h0;
        tmr_sel     = 4'h0;
        miscompares = 0;
        comparisons = 0;
        busy_cnt    = 0;
        hold_cnt    = 0;
        ind_cnt     = 0;
        // Converter taken as powered and clocked from the start
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single_sw();
        t_hw_count();
        t_two_stage();
        t_four_stage();
        end_sim();
    end

    // Tests need well under a thousand cycles; this bound is far above that
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
endmodule : testbench
